// >>> core/capture_pkg.sv
// Shared constants for the three channel input capture block.
package capture_pkg;
    // Bus widths and channel count.
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned CHANNELS = 3;

    // Register word addresses.
    localparam logic [3:0] OFS_CTL_ONE   = 4'h0;
    localparam logic [3:0] OFS_CTL_TWO   = 4'h1;
    localparam logic [3:0] OFS_CTL_THREE = 4'h2;
    localparam logic [3:0] OFS_BUF_ONE   = 4'h3;
    localparam logic [3:0] OFS_BUF_TWO   = 4'h4;
    localparam logic [3:0] OFS_BUF_THREE = 4'h5;
    localparam logic [3:0] OFS_TIME_BASE = 4'h6;
    localparam logic [3:0] OFS_FLAGS     = 4'h7;

    // Control register fields.
    localparam int unsigned REN_BIT  = 6;
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned MODE_W   = 4;

    // Reset values.
    localparam logic [3:0]  MODE_RESET = 4'h0;
    localparam logic        REN_RESET  = 1'b0;
    localparam logic [15:0] TB_RESET   = 16'h0000;
    localparam logic [15:0] TB_CLEARED = 16'h0000;
    localparam logic [15:0] BUF_RESET  = 16'h0000;

    // Mode codes of the capture mode field.
    localparam logic [3:0] MODE_OFF       = 4'h0;
    localparam logic [3:0] MODE_FALL      = 4'h1;
    localparam logic [3:0] MODE_RISE      = 4'h2;
    localparam logic [3:0] MODE_RISE4     = 4'h3;
    localparam logic [3:0] MODE_RISE16    = 4'h4;
    localparam logic [3:0] MODE_PERIOD    = 4'h5;
    localparam logic [3:0] MODE_PW_LOW    = 4'h6;
    localparam logic [3:0] MODE_PW_HIGH   = 4'h7;
    localparam logic [3:0] MODE_CHANGE    = 4'h8;
    localparam logic [3:0] MODE_TRIG_FALL = 4'he;
    localparam logic [3:0] MODE_TRIG_RISE = 4'hf;

    // Prescaler terminal counts.
    localparam logic [1:0] PRESC4_LAST  = 2'h3;
    localparam logic [3:0] PRESC16_LAST = 4'hf;
endpackage : capture_pkg

// >>> core/input_capture_channel.sv
// One capture channel: pin synchroniser, edge decode, prescaler and event pulses.
module input_capture_channel #(
    parameter bit HAS_TRIGGER = 1'b0
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       pin_i,
    input  wire logic [3:0] mode_i,
    input  wire logic       ren_i,
    input  wire logic       mode_wr_i,
    input  wire logic       block_i,
    output logic            capture_o,
    output logic            tb_reset_o,
    output logic            trigger_o
);
    import capture_pkg::*;

    typedef enum logic {ARMED, RUNNING} edge_state_type;

    logic           sync_a;
    logic           sync_b;
    logic           last;
    logic [3:0]     presc;
    edge_state_type state;
    logic           rise;
    logic           fall;
    logic           next_cap;
    logic           next_rst;
    logic           next_trig;

    function automatic logic is_pulse(input logic [3:0] m);
        return (m == MODE_PW_LOW) || (m == MODE_PW_HIGH);
    endfunction : is_pulse

    // Two stage synchroniser; only sync_b and its delayed copy feed the edge logic.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            last   <= 1'b0;
        end else begin
            sync_a <= pin_i; // R11
            sync_b <= sync_a;
            last   <= sync_b;
        end
    end

    assign rise = sync_b & ~last;
    assign fall = ~sync_b & last;

    // Mode decode; the encoder function owns the pins while block_i is high.
    always_comb begin
        next_cap  = 1'b0;
        next_rst  = 1'b0;
        next_trig = 1'b0;
        if (!block_i) begin // R21
            unique case (mode_i)
                MODE_FALL:      next_cap = fall; // R2
                MODE_RISE:      next_cap = rise; // R2
                MODE_RISE4:     next_cap = rise && (presc[1:0] == PRESC4_LAST || state == ARMED); // R2 R12
                MODE_RISE16:    next_cap = rise && (presc == PRESC16_LAST || state == ARMED); // R2 R12
                MODE_PERIOD:    next_cap = rise; // R4
                MODE_PW_HIGH: begin
                    next_cap = fall || (state == ARMED && rise); // R5 R7
                    next_rst = rise; // R6
                end
                MODE_PW_LOW: begin
                    next_cap = rise || (state == ARMED && fall); // R5 R7
                    next_rst = fall; // R6
                end
                MODE_CHANGE:    next_cap = rise || fall; // R8
                MODE_TRIG_FALL: next_trig = HAS_TRIGGER && fall; // R9 R23
                MODE_TRIG_RISE: next_trig = HAS_TRIGGER && rise; // R9 R23
                default:        next_cap = 1'b0; // R22
            endcase
            if (!is_pulse(mode_i)) begin
                next_rst = next_cap && ren_i; // R10
            end
        end
    end

    // Prescaler: cleared only by switching off, so a direct mode change keeps it.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            presc <= 4'h0;
        end else if (mode_i == MODE_OFF) begin
            presc <= 4'h0; // R3
        end else if ((mode_i == MODE_RISE4 || mode_i == MODE_RISE16) && rise && !block_i) begin
            presc <= presc + 4'h1; // R17
        end
    end

    // A mode write re-arms the channel so the next qualifying edge always captures.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ARMED;
        end else if (mode_wr_i) begin
            state <= ARMED; // R12
        end else if (next_cap || next_rst) begin
            state <= RUNNING;
        end
    end

    // Registered event pulses.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            capture_o  <= 1'b0;
            tb_reset_o <= 1'b0;
            trigger_o  <= 1'b0;
        end else begin
            capture_o  <= next_cap;
            tb_reset_o <= next_rst;
            trigger_o  <= next_trig;
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence high_start_seen;
        mode_i == MODE_PW_HIGH && !block_i && rise;
    endsequence

    period_capture_a: assert property ((mode_i == MODE_PERIOD && !block_i && rise) |=> capture_o) // R4
        else $error("period edge not captured");
    pulse_reset_a: assert property (high_start_seen |=> tb_reset_o) // R6
        else $error("pulse start did not reset time base");
    off_clear_a: assert property ((mode_i == MODE_OFF) |=> presc == 4'h0 && !capture_o) // R3
        else $error("channel off but active");
    change_capture_a: assert property ((mode_i == MODE_CHANGE && !block_i && (rise || fall)) |=> capture_o) // R8
        else $error("state change not captured");
    trigger_only_a: assert property (trigger_o |-> !capture_o && !tb_reset_o && HAS_TRIGGER) // R20
        else $error("trigger with capture or on wrong channel");
    encoder_wins_a: assert property (block_i |=> !capture_o && !trigger_o) // R21
        else $error("capture while encoder owns pins");
endmodule : input_capture_channel

// >>> core/three_channel_input_capture.sv
// Three channel input capture with shared time base and register port.
//
// Each instruction cycle is one ref_clk_i period; capture loads happen on the
// edge after the registered channel event, which stands for the first phase.

// Operation
// [R1] Three channels, each with own pin and 16-bit buffer of the time base.
// [R2] Modes capture on falling, rising, every fourth or every sixteenth rising edge.
// [R3] Mode off disables channel and clears its edge prescaler.
// [R4] Period mode captures on rising edges; reset-enable clears time base next cycle.
// [R5] Pulse modes measure high or low pulse between opposite edges.
// [R6] Pulse modes always reset time base on start edge, capture on closing edge.
// [R7] After entering pulse mode, first pin edge captures; first active edge resets.
// [R8] State change mode captures on every rising or falling input change.
// [R9] Channel one only raises special trigger on falling or rising edge.
// [R10] Bit 6 enables time base reset after capture; bits 7,5,4 read zero.
// [R11] Edges pass a synchroniser; buffer loads next phase, reset follows then.
// [R12] First qualifying edge after a mode write always captures the time base.
// [R13] Software time base write wins over a same cycle capture update.
// [R14] Buffers take the incremented time base on the edge after the event.
// [R15] Capture driven reset acts only after the time base value is latched.
// [R16] Software should disable a channel before changing its mode.
// [R17] Direct mode change keeps the prescaler count.
// [R18] Software must run an event counting time base synchronously.
// [R19] Each channel sets its own flag on edge, period, pulse and change events.
// [R20] Trigger mode on channel one sets no flag, only pulses trigger.
// [R21] Encoder function on shared pins takes precedence over capture.
// [R22] Unused mode codes behave as channel off; here they raise no event but leave the prescaler uncleared.
// [R23] Trigger codes on channels two and three produce nothing.
module three_channel_input_capture (
    input  wire logic                           ref_clk_i,
    input  wire logic                           rst_n_i,
    input  wire logic                           capture_pin_one_i,
    input  wire logic                           capture_pin_two_i,
    input  wire logic                           capture_pin_three_i,
    input  wire logic                           quadrature_encoder_function_i,
    input  wire logic [capture_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [capture_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                           wr_i,
    input  wire logic                           rd_i,
    output logic      [capture_pkg::DATA_W-1:0] rdata_o,
    output logic                                trigger_o,
    output logic                                channel_one_event_flag_o,
    output logic                                channel_two_event_flag_o,
    output logic                                channel_three_event_flag_o
);
    import capture_pkg::*;

    logic [3:0]        mode [CHANNELS];
    logic              ren [CHANNELS];
    logic [15:0]       capture_buffer [CHANNELS];
    logic [2:0]        flags;
    logic [15:0]       shared_time_base;
    logic              reset_pending;
    logic [2:0]        pins;
    logic [2:0]        mode_wr;
    logic [2:0]        cap;
    logic [2:0]        tb_rst;
    logic [2:0]        trig;
    logic              tb_wr;
    logic              flag_wr;
    logic [15:0]       next_time_base;
    logic [15:0]       next_rdata;

    assign pins  = {capture_pin_three_i, capture_pin_two_i, capture_pin_one_i};
    assign tb_wr = wr_i && addr_i == OFS_TIME_BASE;
    assign flag_wr = wr_i && addr_i == OFS_FLAGS;

    // Maps a control register address to its channel write strobe.
    function automatic logic [2:0] ctl_select(input logic [3:0] a);
        logic [2:0] s;
        s = 3'h0;
        if (a == OFS_CTL_ONE) begin
            s = 3'h1;
        end else if (a == OFS_CTL_TWO) begin
            s = 3'h2;
        end else if (a == OFS_CTL_THREE) begin
            s = 3'h4;
        end
        return s;
    endfunction : ctl_select

    // Control byte as software reads it: only the enable and mode hold storage.
    function automatic logic [15:0] ctl_word(input logic r, input logic [3:0] m);
        logic [15:0] w;
        w = 16'h0000;
        w[REN_BIT] = r; // R10
        w[MODE_LSB +: MODE_W] = m;
        return w;
    endfunction : ctl_word

    assign mode_wr = wr_i ? ctl_select(addr_i) : 3'h0;

    // One channel per pin; only the first carries the special event trigger.
    for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
        input_capture_channel #(
            .HAS_TRIGGER (i == 0) // R9 R23
        ) u_chan (
            .ref_clk_i  (ref_clk_i),
            .rst_n_i    (rst_n_i),
            .pin_i      (pins[i]),
            .mode_i     (mode[i]),
            .ren_i      (ren[i]),
            .mode_wr_i  (mode_wr[i]),
            .block_i    (quadrature_encoder_function_i),
            .capture_o  (cap[i]),
            .tb_reset_o (tb_rst[i]),
            .trigger_o  (trig[i])
        );
    end

    // Control registers; a mode change does not touch the time base.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < CHANNELS; i++) begin
                mode[i] <= MODE_RESET;
                ren[i]  <= REN_RESET;
            end
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (mode_wr[i]) begin
                    mode[i] <= wdata_i[MODE_LSB +: MODE_W];
                    ren[i]  <= wdata_i[REN_BIT]; // R10
                end
            end
        end
    end

    // Value the time base takes at this edge; buffers latch the same value.
    always_comb begin
        if (tb_wr) begin
            next_time_base = wdata_i; // R13
        end else if (reset_pending) begin
            next_time_base = TB_CLEARED; // R15
        end else begin
            next_time_base = shared_time_base + 16'h0001; // R14
        end
    end

    // Free running time base; the reset lands one cycle after the latch.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shared_time_base <= TB_RESET;
        end else begin
            shared_time_base <= next_time_base;
        end
    end

    // Reset request is held one cycle so no buffer ever sees the cleared value
    // in place of the count that the edge belonged to.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reset_pending <= 1'b0;
        end else begin
            reset_pending <= (|tb_rst) && !tb_wr; // R4 R6 R11 R15
        end
    end

    // Capture buffers load on the edge after the registered event.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < CHANNELS; i++) begin
                capture_buffer[i] <= BUF_RESET;
            end
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (cap[i]) begin
                    capture_buffer[i] <= next_time_base; // R1 R11 R14
                end
            end
        end
    end

    // Event flags: a new event beats a write-one-to-clear in the same cycle.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags <= 3'h0;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (cap[i]) begin
                    flags[i] <= 1'b1; // R19
                end else if (flag_wr && wdata_i[i]) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    end

    assign channel_one_event_flag_o   = flags[0];
    assign channel_two_event_flag_o   = flags[1];
    assign channel_three_event_flag_o = flags[2];
    assign trigger_o                  = trig[0]; // R9 R20

    // Read decode; unmapped addresses answer zero.
    always_comb begin
        unique case (addr_i)
            OFS_CTL_ONE:   next_rdata = ctl_word(ren[0], mode[0]);
            OFS_CTL_TWO:   next_rdata = ctl_word(ren[1], mode[1]);
            OFS_CTL_THREE: next_rdata = ctl_word(ren[2], mode[2]);
            OFS_BUF_ONE:   next_rdata = capture_buffer[0];
            OFS_BUF_TWO:   next_rdata = capture_buffer[1];
            OFS_BUF_THREE: next_rdata = capture_buffer[2];
            OFS_TIME_BASE: next_rdata = shared_time_base;
            OFS_FLAGS:     next_rdata = {13'h0000, flags};
            default:       next_rdata = 16'h0000;
        endcase
    end

    // Read data stands for exactly one cycle after the strobe.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rd_i ? next_rdata : 16'h0000;
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence capture_reset_seen;
        tb_rst[0] && cap[0] && !tb_wr;
    endsequence

    sequence quiet_next;
        !tb_wr && !(|tb_rst);
    endsequence

    buffer_load_a: assert property ((cap[0] && !tb_wr && !reset_pending)
        |=> capture_buffer[0] == $past(shared_time_base) + 16'h0001) // R14
        else $error("buffer missed incremented time base");
    reset_after_latch_a: assert property (capture_reset_seen ##1 quiet_next
        |=> shared_time_base == TB_CLEARED) // R15
        else $error("time base not cleared after capture");
    latch_before_reset_a: assert property ((capture_reset_seen ##1 !tb_wr)
        |-> capture_buffer[0] != TB_CLEARED || $past(shared_time_base) == 16'hffff) // R15
        else $error("time base cleared before latch");
    write_wins_a: assert property (tb_wr |=> shared_time_base == $past(wdata_i)) // R13
        else $error("time base write lost");
    flag_set_a: assert property (cap[1] |=> channel_two_event_flag_o) // R19
        else $error("flag not set by capture");
    ctl_reserved_a: assert property ((rd_i && addr_i == OFS_CTL_ONE)
        |=> rdata_o[7] == 1'b0 && rdata_o[5:4] == 2'h0 && rdata_o[6] == ren[0]) // R10
        else $error("control reserved bits not zero");
    read_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data outside read cycle");
    unused_quiet_a: assert property ((mode[2] == 4'h9) |=> !cap[2] && !tb_rst[2]) // R22
        else $error("unused mode produced event");
endmodule : three_channel_input_capture

// >>> verif/hall_source.sv
// Pulse source model that stands in for the Hall sensors on the capture pins.
module hall_source (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       go_i,
    input  wire logic [2:0] mask_i,
    input  wire logic [3:0] edges_i,
    input  wire logic [3:0] high_len_i,
    input  wire logic [3:0] low_len_i,
    output logic      [2:0] pins_o,
    output logic            busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] left;
    logic [3:0] wait_cnt;
    logic       level;
    logic [3:0] hold_high;
    logic [3:0] hold_low;

    // A length below two cycles is raised to two, so a zero length never wraps the wait counter.
    assign hold_high = (high_len_i < 4'h2) ? 4'h2 : high_len_i;
    assign hold_low  = (low_len_i < 4'h2) ? 4'h2 : low_len_i;
    assign busy_o    = (left != 4'h0);

    // Toggle the selected pins, each new level held for its own length.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pins_o   <= 3'h0;
            left     <= 4'h0;
            wait_cnt <= 4'h0;
            level    <= 1'b0;
        end else if (go_i) begin
            pins_o   <= pins_o ^ mask_i;
            level    <= ~level;
            left     <= edges_i - 4'h1;
            wait_cnt <= (level ? hold_low : hold_high) - 4'h1;
        end else if (left != 4'h0) begin
            if (wait_cnt == 4'h0) begin
                pins_o   <= pins_o ^ mask_i;
                level    <= ~level;
                left     <= left - 4'h1;
                wait_cnt <= (level ? hold_low : hold_high) - 4'h1;
            end else begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end
endmodule : hall_source

// >>> verif/three_channel_input_capture_bench.sv
// Self-checking bench for the three channel input capture block.
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] %0t: got %h expected %h", $time, got, exp); end end
module three_channel_input_capture_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import capture_pkg::*;
    typedef struct {int ch; logic [3:0] m; logic ren; logic enc;} scen_type;
    logic        ref_clk_i;
    logic        rst_n_i = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        rd_q = 1'b0;
    logic        enc = 1'b0;
    logic        go = 1'b0;
    logic [2:0]  mask = 3'h0;
    logic [3:0]  hlen = 4'h2;
    logic [3:0]  llen = 4'h2;
    logic [3:0]  nedge = 4'h6;
    logic [2:0]  pins;
    logic        busy;
    logic [15:0] rdata_o;
    logic        trigger_o;
    logic [2:0]  flags;
    logic [15:0] ev;
    logic [15:0] exp_buf [3] = '{16'h0000, 16'h0000, 16'h0000};
    logic [15:0] expq [$];
    scen_type    tbl [14];
    int          n_errors = 0;
    int          checks_done = 0;
    int          trig_seen = 0;
    int          cycles = 0;
    int          seed = 32'he4ec7915;

    three_channel_input_capture u_dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .capture_pin_one_i(pins[0]), .capture_pin_two_i(pins[1]),
        .capture_pin_three_i(pins[2]), .quadrature_encoder_function_i(enc), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trigger_o(trigger_o),
        .channel_one_event_flag_o(flags[0]), .channel_two_event_flag_o(flags[1]),
        .channel_three_event_flag_o(flags[2]));
    hall_source u_src (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .go_i(go), .mask_i(mask), .edges_i(nedge),
        .high_len_i(hlen), .low_len_i(llen), .pins_o(pins), .busy_o(busy));

    // Free-running clock of one instruction cycle per period.
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // Results are taken at the falling edge, well clear of the launching edge.
    always @(posedge ref_clk_i) rd_q <= rd_i;
    always @(negedge ref_clk_i) begin
        if (trigger_o !== 1'b0) trig_seen++;
        if (rd_q) begin
            ev = expq.pop_front();
            `CHECK(rdata_o, ev)
        end
    end

    // A hung handshake ends the run as a failure instead of spinning forever.
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        expq.push_back(e);
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
    endtask : rd_chk

    // Time base load and first pin toggle land on the same edge, so capture times are known.
    task automatic arm(input logic [15:0] w);
        @(posedge ref_clk_i);
        addr_i  <= OFS_TIME_BASE;
        wdata_i <= w;
        wr_i    <= 1'b1;
        go      <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        go   <= 1'b0;
    endtask : arm

    task automatic settle();
        int g;
        g = 0;
        @(posedge ref_clk_i);
        while (busy !== 1'b0 && g < 300) begin
            @(posedge ref_clk_i);
            g++;
        end
        repeat (8) @(posedge ref_clk_i);
    endtask : settle

    // Reference: buffer is time base four edges after the toggle; a reset zeroes it one edge later.
    function automatic logic [16:0] ref_cap(input logic [3:0] m, input logic ren, input int n, h, l,
                                            input logic [15:0] w);
        logic [15:0] base;
        logic [16:0] res;
        int          t, t0, i;
        logic        rise, first, cap, rst, pw;
        base = w;
        t0 = 0;
        t = 0;
        first = 1'b1;
        res = 17'h00000;
        pw = (m == MODE_PW_LOW) || (m == MODE_PW_HIGH);
        for (i = 0; i < n; i++) begin
            rise = (i % 2 == 0);
            case (m)
                MODE_FALL:               cap = !rise;
                MODE_RISE, MODE_PERIOD:  cap = rise;
                MODE_RISE4, MODE_RISE16: cap = rise && first;
                MODE_PW_HIGH:            cap = !rise || first;
                MODE_PW_LOW:             cap = rise || first;
                MODE_CHANGE:             cap = 1'b1;
                default:                 cap = 1'b0;
            endcase
            rst = pw ? (rise == (m == MODE_PW_HIGH)) : (cap && ren);
            if (cap) res = {1'b1, base + 16'(t + 4 - t0)};
            if (cap) first = 1'b0;
            if (rst) begin
                base = 16'h0000;
                t0 = t + 5;
            end
            t += rise ? h : l;
        end
        return res;
    endfunction : ref_cap

    task automatic run(input scen_type s);
        logic [16:0] r;
        logic [15:0] w;
        int          h, l;
        h = 2 + {$random(seed)} % 6;
        l = 2 + {$random(seed)} % 6;
        w = 16'($random(seed));
        wr_reg(OFS_CTL_ONE + 4'(s.ch), 16'h0000);
        wr_reg(OFS_FLAGS, 16'h0007);
        enc <= s.enc;
        wr_reg(OFS_CTL_ONE + 4'(s.ch), {9'h000, s.ren, 2'b00, s.m});
        trig_seen = 0;
        mask  <= 3'(1 << s.ch);
        hlen  <= 4'(h);
        llen  <= 4'(l);
        nedge <= 4'h6;
        arm(w);
        settle();
        r = ref_cap(s.enc ? MODE_OFF : s.m, s.ren, 6, h, l, w);
        if (r[16]) exp_buf[s.ch] = r[15:0];
        rd_chk(OFS_BUF_ONE + 4'(s.ch), exp_buf[s.ch]);
        rd_chk(OFS_FLAGS, 16'(r[16]) << s.ch);
        enc <= 1'b0;
        // Flag pins are looked at half a cycle after the edge, never in the edge's own time step.
        @(negedge ref_clk_i);
        `CHECK(flags, 3'(r[16]) << s.ch)
        `CHECK(trig_seen, (s.ch == 0 && s.m >= MODE_TRIG_FALL && !s.enc) ? 3 : 0)
    endtask : run

    // Main sequence: register map first, then every named mode but off, plus unused codes 9 and d, through the pulse source.
    initial begin
        tbl = '{'{0, MODE_FALL, 1'b0, 1'b0}, '{1, MODE_RISE, 1'b1, 1'b0}, '{2, MODE_RISE4, 1'b0, 1'b0},
                '{0, MODE_RISE16, 1'b1, 1'b0}, '{1, MODE_PERIOD, 1'b1, 1'b0}, '{2, MODE_PW_LOW, 1'b0, 1'b0},
                '{0, MODE_PW_HIGH, 1'b0, 1'b0}, '{1, MODE_CHANGE, 1'b1, 1'b0}, '{0, MODE_TRIG_FALL, 1'b0, 1'b0},
                '{0, MODE_TRIG_RISE, 1'b1, 1'b0}, '{1, MODE_TRIG_RISE, 1'b0, 1'b0}, '{2, 4'h9, 1'b1, 1'b0},
                '{0, 4'hd, 1'b0, 1'b0}, '{0, MODE_RISE, 1'b1, 1'b1}};
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            if (a != 6) rd_chk(4'(a), 16'h0000);
        end
        wr_reg(OFS_CTL_TWO, 16'hffff);
        rd_chk(OFS_CTL_TWO, 16'h004f);
        wr_reg(OFS_CTL_TWO, 16'h0000);
        wr_reg(4'h9, 16'hffff);
        wr_reg(OFS_BUF_ONE, 16'hffff);
        rd_chk(OFS_BUF_ONE, 16'h0000);
        wr_reg(OFS_TIME_BASE, 16'h1234);
        rd_chk(OFS_TIME_BASE, 16'h1235);
        foreach (tbl[k]) run(tbl[k]);
        // A time base write on the capture edge must be what the buffer keeps.
        wr_reg(OFS_CTL_ONE, {12'h000, MODE_RISE});
        nedge <= 4'h2;
        mask  <= 3'h1;
        arm(16'h0100);
        repeat (2) @(posedge ref_clk_i);
        wr_reg(OFS_TIME_BASE, 16'hbeef);
        settle();
        rd_chk(OFS_BUF_ONE, 16'hbeef);
        end_of_test();
    end
endmodule : three_channel_input_capture_bench
